// >>> hw/icx_pkg.sv
`default_nettype none
package icx_pkg;
  // clock and sequencing figures, in cycles of hclk
  localparam int unsigned CLK_HZ    = 10_000_000;
  localparam int unsigned ENTRY_CYC = 4;
  localparam int unsigned RET_CYC   = 4;
  localparam int unsigned WAKE_CYC  = 4;
  localparam int unsigned CNT_W     = 3;
  localparam logic [CNT_W-1:0] ENTRY_LAST = CNT_W'(ENTRY_CYC - 1);
  localparam logic [CNT_W-1:0] RET_LAST   = CNT_W'(RET_CYC - 1);
  localparam logic [CNT_W-1:0] WAKE_LAST  = CNT_W'(WAKE_CYC - 1);

  // address widths of program counter and stack pointer
  localparam int unsigned PC_W = 12;
  localparam int unsigned SP_W = 16;
  localparam logic [SP_W-1:0] SP_RST  = 16'h0000;
  localparam logic [SP_W-1:0] SP_STEP = 16'h0001;
  localparam logic [PC_W-1:0] VEC_LOW = 12'h000;

  // register byte offsets on the bus
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_IRQCTL = 8'h04;
  localparam logic [7:0] OFF_EN     = 8'h08;
  localparam logic [7:0] OFF_FLAG   = 8'h0c;
  localparam logic [7:0] OFF_SP     = 8'h10;
  localparam logic [7:0] OFF_STATE  = 8'h14;

  // field positions
  localparam int unsigned GIE_BIT   = 7;
  localparam int unsigned RELOC_BIT = 1;
  localparam int unsigned STATE_LSB = 0;
  localparam int unsigned HOLD_BIT  = 4;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef enum logic [1:0] {ST_RUN, ST_WAKE, ST_ENTRY, ST_RET} icx_state_e;
endpackage
`default_nettype wire

// >>> hw/icx_irq_ctrl.sv
// Function
// [R01] logic runs directly on hclk, no internal divider
// [R02] ordinary instructions complete without stall from this block
// [R03] reset and every source own separate vectors, lowest addresses by default
// [R04] among pending requests the lowest vector wins
// [R05] reset beats all; source zero ranks next
// [R06] service needs own enable and global enable both set
// [R07] boot lock settings suppress interrupts by current pc region
// [R08] relocate bit moves vectors to boot section start
// [R09] boot reset fuse moves reset vector to boot section start
// [R10] taking an interrupt clears global enable; software may re-enable
// [R11] vectoring clears the flag of a flag-type source
// [R12] writing one clears a flag; zero leaves it
// [R13] event while disabled still sets flag and holds it
// [R14] flags pending while global enable off are served by priority later
// [R15] level sources request only while condition present
// [R16] after return one main instruction runs before next entry
// [R17] status register not saved or restored by hardware
// [R18] disable instruction blocks interrupts at once, same cycle included
// [R19] after enable instruction the next instruction completes first
// [R20] entry takes four cycles and pushes the pc
// [R21] multi-cycle instruction finishes before entry starts
// [R22] wake from sleep adds four cycles to entry
// [R23] return takes four cycles, pops pc, sp plus two, sets enable
// [R24] entry push decrements stack pointer by two
// [R25] one-cycle acknowledge to chosen source at vectoring
// [R26] priority chosen only at instruction boundaries
`timescale 1ns/1ps
`default_nettype none
module icx_irq_ctrl #(
  parameter int unsigned           NSRC      = 8,
  parameter logic [NSRC-1:0]       LEVEL_SRC = '0,
  parameter logic [icx_pkg::PC_W-1:0] BOOT_START = 12'hc00
) (
  // clock and reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // ahb-lite slave
  input  wire logic                     hsel,
  input  wire logic [7:0]               haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  // interrupt sources
  input  wire logic [NSRC-1:0]          src_event,
  input  wire logic [NSRC-1:0]          src_level,
  output logic      [NSRC-1:0]          src_ack,
  // straps
  input  wire logic                     app_section_lock_bit,
  input  wire logic                     boot_section_lock_bit,
  input  wire logic                     boot_reset_vector_fuse,
  // instruction sequencer
  input  wire logic                     instr_done,
  input  wire logic                     instr_cli,
  input  wire logic                     instr_sei,
  input  wire logic                     return_from_handler_instr,
  input  wire logic                     cpu_sleep,
  input  wire logic [icx_pkg::PC_W-1:0] pc_in,
  output logic                          core_hold,
  output logic                          irq_take,
  output logic                          pc_load,
  output logic      [icx_pkg::PC_W-1:0] pc_load_addr,
  output logic      [icx_pkg::PC_W-1:0] reset_vec,
  // stack memory port
  output logic                          stk_we,
  output logic                          stk_re,
  output logic      [icx_pkg::SP_W-1:0] stk_addr,
  output logic      [7:0]               stk_wdata,
  input  wire logic [7:0]               stk_rdata
);
  import icx_pkg::*;

  // flag and enable words must fit the low bits of one bus word, refused at elaboration
  if (NSRC < 1 || NSRC > 24) begin : g_nsrc_chk
    $error("icx_irq_ctrl: NSRC must be 1..24");
  end

  icx_state_e            st_ff;
  logic [CNT_W-1:0]      cnt_ff;
  logic                  gie_ff;
  logic                  reloc_ff;
  logic [NSRC-1:0]       en_ff;
  logic [NSRC-1:0]       flag_ff;
  logic [SP_W-1:0]       sp_ff;
  logic [PC_W-9:0]       ret_pc_ff;
  logic [PC_W-1:0]       vec_ff;
  logic                  wake_ff;
  logic                  wr_ff;
  logic [7:0]            waddr_ff;
  logic                  ahb_go;
  logic [NSRC-1:0]       pend;
  logic [NSRC-1:0]       req;
  logic [NSRC-1:0]       win;
  logic                  in_boot;
  logic                  lock_blk;
  logic                  take;
  logic                  ret_go;
  logic [31:0]           nxt_rdata;

  // pending set: flag-type sources latch, level-type follow the line
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      assign pend[g] = LEVEL_SRC[g] ? src_level[g] : flag_ff[g]; // see [R15]
    end
  endgenerate

  assign req = pend & en_ff;                              // see [R06]
  assign win = req & (~req + NSRC'(1));                   // lowest index wins, see [R04] [R05]

  // region check against the boot lock settings
  assign in_boot  = (pc_in >= BOOT_START);
  assign lock_blk = (app_section_lock_bit && !in_boot && reloc_ff) ||
                    (boot_section_lock_bit && in_boot && !reloc_ff); // see [R07]

  // entry decision only at a boundary; sei and cli boundaries never take
  assign take = (st_ff == ST_RUN) && instr_done && gie_ff && (|req) && !lock_blk &&
                !instr_cli && !instr_sei && !return_from_handler_instr; // see [R18] [R19] [R21] [R26]
  assign ret_go = (st_ff == ST_RUN) && instr_done && return_from_handler_instr;

  // sequencing fsm on the undivided clock
  always_ff @(posedge hclk or negedge hresetn) begin // see [R01]
    if (!hresetn) begin
      st_ff   <= ST_RUN;
      cnt_ff  <= '0;
      wake_ff <= 1'b0;
    end else begin
      case (st_ff)
        ST_RUN: begin
          cnt_ff <= '0;
          if (take) begin
            st_ff   <= cpu_sleep ? ST_WAKE : ST_ENTRY; // see [R22]
            wake_ff <= cpu_sleep;
          end else if (ret_go) begin
            st_ff <= ST_RET;
          end
        end
        ST_WAKE: begin
          cnt_ff <= cnt_ff + CNT_W'(1);
          if (cnt_ff == WAKE_LAST) begin
            st_ff  <= ST_ENTRY;
            cnt_ff <= '0;
          end
        end
        ST_ENTRY: begin
          cnt_ff <= cnt_ff + CNT_W'(1);
          if (cnt_ff == ENTRY_LAST) begin
            st_ff   <= ST_RUN;  // see [R20]
            wake_ff <= 1'b0;
          end
        end
        ST_RET: begin
          cnt_ff <= cnt_ff + CNT_W'(1);
          if (cnt_ff == RET_LAST) st_ff <= ST_RUN; // see [R23]
        end
        default: st_ff <= ST_RUN;
      endcase
    end
  end

  // sequencer handshake: hold core only while entering or returning
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_hold    <= 1'b0;
      irq_take     <= 1'b0;
      src_ack      <= '0;
      vec_ff       <= VEC_LOW;
      pc_load      <= 1'b0;
      pc_load_addr <= VEC_LOW;
    end else begin
      core_hold <= (take || ret_go) ? 1'b1 : (pc_load ? 1'b0 : core_hold); // see [R02]
      irq_take  <= take;
      src_ack   <= take ? win : '0;                                         // see [R25]
      if (take) begin
        for (int i = 0; i < NSRC; i++) begin
          if (win[i]) vec_ff <= (reloc_ff ? BOOT_START : VEC_LOW) + PC_W'(i + 1); // see [R03] [R08]
        end
      end
      pc_load <= ((st_ff == ST_ENTRY) && (cnt_ff == ENTRY_LAST)) ||
                 ((st_ff == ST_RET) && (cnt_ff == RET_LAST));
      if ((st_ff == ST_ENTRY) && (cnt_ff == ENTRY_LAST)) pc_load_addr <= vec_ff;
      if ((st_ff == ST_RET) && (cnt_ff == RET_LAST))
        pc_load_addr <= {ret_pc_ff, stk_rdata}; // popped pc, see [R16] [R23]
    end
  end

  // reset vector follows the fuse, caught after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) reset_vec <= VEC_LOW;
    else          reset_vec <= boot_reset_vector_fuse ? BOOT_START : VEC_LOW; // see [R09]
  end

  // stack traffic: push low then high on entry, pop high then low on return
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_ff     <= SP_RST;
      stk_we    <= 1'b0;
      stk_re    <= 1'b0;
      stk_addr  <= SP_RST;
      stk_wdata <= 8'h00;
      ret_pc_ff <= '0;
    end else begin
      stk_we <= 1'b0;
      stk_re <= 1'b0;
      if ((st_ff == ST_ENTRY) && (cnt_ff < CNT_W'(2))) begin // only pc, never status, see [R17]
        stk_we    <= 1'b1;
        stk_addr  <= sp_ff;
        stk_wdata <= (cnt_ff == '0) ? pc_in[7:0] : 8'(pc_in[PC_W-1:8]);
        sp_ff     <= sp_ff - SP_STEP;                  // see [R24]
      end else if ((st_ff == ST_RET) && (cnt_ff < CNT_W'(2))) begin
        stk_re   <= 1'b1;
        stk_addr <= sp_ff + SP_STEP;
        sp_ff    <= sp_ff + SP_STEP;                   // see [R23]
      end else if (wr_ff && (waddr_ff == OFF_SP)) begin
        sp_ff <= hwdata[SP_W-1:0];
      end
      // memory answers one cycle after the registered strobe: high byte lands at
      // count two, the low byte goes straight into the load at the last count
      if ((st_ff == ST_RET) && (cnt_ff == CNT_W'(2))) ret_pc_ff <= stk_rdata[PC_W-9:0];
    end
  end

  // global enable: hardware events outrank software writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) gie_ff <= 1'b0;
    else if (take) gie_ff <= 1'b0;                                        // see [R10]
    else if ((st_ff == ST_RET) && (cnt_ff == RET_LAST)) gie_ff <= 1'b1;  // see [R23]
    else if (instr_done && instr_cli) gie_ff <= 1'b0;                     // see [R18]
    else if (instr_done && instr_sei) gie_ff <= 1'b1;                     // see [R19]
    else if (wr_ff && (waddr_ff == OFF_STATUS)) gie_ff <= hwdata[GIE_BIT]; // see [R10]
  end

  // flags: events set, ack or write-one clears, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) flag_ff <= '0;
    else flag_ff <= ((flag_ff & ~(take ? win : '0) &                        // see [R11]
                     ~((wr_ff && (waddr_ff == OFF_FLAG)) ? hwdata[NSRC-1:0] : '0)) | // see [R12]
                     src_event) & ~LEVEL_SRC;                               // see [R13] [R14]
  end

  // control registers written by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_ff    <= '0;
      reloc_ff <= 1'b0;
    end else if (wr_ff) begin
      if (waddr_ff == OFF_EN)     en_ff    <= hwdata[NSRC-1:0];
      if (waddr_ff == OFF_IRQCTL) reloc_ff <= hwdata[RELOC_BIT]; // see [R08]
    end
  end

  // ahb-lite slave: zero wait, read data prepared in the address phase
  assign ahb_go = hsel && hready && (htrans == HTRANS_NONSEQ);

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (haddr)
      OFF_STATUS: nxt_rdata[GIE_BIT]   = gie_ff;
      OFF_IRQCTL: nxt_rdata[RELOC_BIT] = reloc_ff;
      OFF_EN:     nxt_rdata[NSRC-1:0]  = en_ff;
      OFF_FLAG:   nxt_rdata[NSRC-1:0]  = pend;
      OFF_SP:     nxt_rdata[SP_W-1:0]  = sp_ff;
      OFF_STATE: begin
        nxt_rdata[STATE_LSB +: 2] = st_ff;
        nxt_rdata[HOLD_BIT]       = core_hold;
      end
      default:    nxt_rdata = 32'h0000_0000; // unmapped reads zero, writes dropped
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff     <= 1'b0;
      waddr_ff  <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
      wr_ff     <= ahb_go && hwrite && (hsize == 3'h2);
      waddr_ff  <= haddr;
      if (ahb_go && !hwrite) hrdata <= nxt_rdata;
    end
  end

  // checks
  sequence s_entry;
    ##4 pc_load;
  endsequence
  sequence s_return;
    ##4 (pc_load && gie_ff);
  endsequence

  property p_entry_len;
    @(posedge hclk) disable iff (!hresetn) irq_take && !wake_ff |-> s_entry;
  endproperty
  a_entry_len: assert property (p_entry_len) else $error("entry not four cycles"); // see [R20]

  property p_wake_len;
    @(posedge hclk) disable iff (!hresetn) irq_take && wake_ff |-> ##8 pc_load;
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake entry not eight cycles"); // see [R22]

  property p_ret_len;
    @(posedge hclk) disable iff (!hresetn) ret_go |=> s_return;
  endproperty
  a_ret_len: assert property (p_ret_len) else $error("return timing wrong"); // see [R23]

  property p_cli;
    @(posedge hclk) disable iff (!hresetn) instr_done && instr_cli |=> !irq_take ##1 !irq_take;
  endproperty
  a_cli: assert property (p_cli) else $error("take after disable"); // see [R18]

  property p_gie_clr;
    @(posedge hclk) disable iff (!hresetn) irq_take |-> !gie_ff && $past(gie_ff);
  endproperty
  a_gie_clr: assert property (p_gie_clr) else $error("enable not cleared on take"); // see [R10]

  property p_sp_push;
    @(posedge hclk) disable iff (!hresetn)
      irq_take && !wake_ff |-> ##4 (sp_ff == $past(sp_ff, 4) - 16'h0002);
  endproperty
  a_sp_push: assert property (p_sp_push) else $error("push not minus two"); // see [R24]

  property p_sp_pop;
    @(posedge hclk) disable iff (!hresetn) ret_go |=> ##3 (sp_ff == $past(sp_ff, 4) + 16'h0002);
  endproperty
  a_sp_pop: assert property (p_sp_pop) else $error("pop not plus two"); // see [R23]

  property p_ack;
    @(posedge hclk) disable iff (!hresetn)
      irq_take |-> $onehot(src_ack) && ((src_ack & $past(req)) == src_ack) ##1 (src_ack == '0);
  endproperty
  a_ack: assert property (p_ack) else $error("ack not single pulse of pending"); // see [R25]

  property p_prio;
    @(posedge hclk) disable iff (!hresetn)
      irq_take |-> ((src_ack - NSRC'(1)) & $past(req)) == '0;
  endproperty
  a_prio: assert property (p_prio) else $error("lower index pending was skipped"); // see [R04]

endmodule // icx_irq_ctrl
`default_nettype wire

// >>> test/icx_stack_model.sv
`timescale 1ns/1ps
`default_nettype none
module icx_stack_model (
  // clock
  input  wire logic        hclk,
  // stack memory port
  input  wire logic        stk_we,
  input  wire logic        stk_re,
  input  wire logic [15:0] stk_addr,
  input  wire logic [7:0]  stk_wdata,
  output logic      [7:0]  stk_rdata
);
  logic [7:0] mem_ff [0:511];

  // data is valid only in the cycle after a read strobe; otherwise the line
  // toggles so that a late or early sample never matches by chance
  always @(posedge hclk) begin
    if (stk_we) mem_ff[stk_addr[8:0]] <= stk_wdata;
    stk_rdata <= stk_re ? mem_ff[stk_addr[8:0]] : ~stk_rdata;
  end
endmodule // icx_stack_model
`default_nettype wire

// >>> test/icx_irq_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module icx_irq_ctrl_tb_top;
  import icx_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr, src_event, src_level, src_ack, stk_wdata, stk_rdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic        lk_app, lk_boot, fuse, done, cli, sei, ret, slp;
  logic        hold, take, load, stk_we, stk_re, early;
  logic [11:0] pc_in, load_addr, rvec;
  logic [15:0] stk_addr;
  int          n_mismatch, check_count;

  icx_irq_ctrl #(.LEVEL_SRC(8'h80)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_event(src_event),
    .src_level(src_level), .src_ack(src_ack), .app_section_lock_bit(lk_app),
    .boot_section_lock_bit(lk_boot), .boot_reset_vector_fuse(fuse),
    .instr_done(done), .instr_cli(cli), .instr_sei(sei),
    .return_from_handler_instr(ret), .cpu_sleep(slp), .pc_in(pc_in),
    .core_hold(hold), .irq_take(take), .pc_load(load), .pc_load_addr(load_addr),
    .reset_vec(rvec), .stk_we(stk_we), .stk_re(stk_re), .stk_addr(stk_addr),
    .stk_wdata(stk_wdata), .stk_rdata(stk_rdata));

  icx_stack_model i_stk (.hclk(hclk), .stk_we(stk_we), .stk_re(stk_re),
    .stk_addr(stk_addr), .stk_wdata(stk_wdata), .stk_rdata(stk_rdata));

  // clock, 100 ns period
  always #50 hclk = ~hclk;

  task automatic check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one single word transfer; waits on hready for each phase, no fixed latency
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; hwrite <= wr; hsize <= 3'h2; htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (!hreadyout);
    htrans <= 2'h0; hwdata <= wr ? d : 32'h0;
    do @(posedge hclk); while (!hreadyout);
    rd = hrdata;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(what, rd, e);
  endtask

  // one instruction boundary; k = {sleep, return, sei, cli}
  task automatic bound(input logic [3:0] k);
    @(posedge hclk);
    done <= 1'b1; {slp, ret, sei, cli} <= k;
    @(posedge hclk);
    done <= 1'b0; {slp, ret, sei, cli} <= 4'h0;
    #1;
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge hclk); src_event <= m;
    @(posedge hclk); src_event <= 8'h00;
  endtask

  // pc_load must come exactly lat cycles after the accepting edge
  task automatic load_after(input int lat, input logic [11:0] a);
    early = 1'b0;
    for (int i = 1; i < lat; i++) begin
      @(posedge hclk); #1;
      early |= load;
    end
    @(posedge hclk); #1;
    check("early_load", early, 1'b0);
    check("pc_load", load, 1'b1);
    check("load_addr", load_addr, a);
  endtask

  task automatic no_take(input string what);
    early = 1'b0;
    repeat (6) begin
      early |= take;
      @(posedge hclk); #1;
    end
    check(what, early, 1'b0);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // watchdog, far beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge hclk);
    n_mismatch++;
    close_out();
  end

  initial begin
    hclk = 0; hresetn = 0; hsel = 0; hwrite = 0; haddr = 8'h00; htrans = 2'h0;
    hsize = 3'h2; hwdata = 32'h0; src_event = 8'h00; src_level = 8'h00;
    lk_app = 0; lk_boot = 0; fuse = 0; done = 0; cli = 0; sei = 0; ret = 0;
    slp = 0; pc_in = 12'h123; n_mismatch = 0; check_count = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, stack pointer, unmapped place
    rd_chk("status", OFF_STATUS, 32'h0);
    rd_chk("sp", OFF_SP, 32'h0);
    rd_chk("state", OFF_STATE, 32'h0);
    rd_chk("unmapped", 8'h20, 32'h0);
    check("hresp", hresp, HRESP_OKAY);
    check("reset_vec", rvec, 12'h000);
    bus(1'b1, OFF_SP, 32'h100);
    rd_chk("sp", OFF_SP, 32'h100);
    $display("test registers done");
    // events while disabled stay pending
    pulse(8'h24);
    rd_chk("flag", OFF_FLAG, 32'h24);
    bus(1'b1, OFF_EN, 32'h24);
    bound(4'h0);
    no_take("gie_off");
    bus(1'b1, OFF_STATUS, 32'h80);
    bound(4'h1);
    no_take("cli_take");
    bus(1'b1, OFF_STATUS, 32'h80);
    bound(4'h2);
    no_take("sei_take");
    // entry: lowest vector wins, four cycles, two bytes pushed
    bound(4'h0);
    check("take", take, 1'b1);
    check("hold", hold, 1'b1);
    check("ack", src_ack, 8'h04);
    load_after(ENTRY_CYC, 12'h003);
    check("push_lo", i_stk.mem_ff[9'h100], 8'h23);
    check("push_hi", i_stk.mem_ff[9'h0ff], 8'h01);
    rd_chk("sp_entry", OFF_SP, 32'h0fe);
    check("hold_off", hold, 1'b0);
    rd_chk("gie_entry", OFF_STATUS, 32'h0);
    rd_chk("flag_hw", OFF_FLAG, 32'h20);
    $display("test entry done");
    // return: pop, sp back by two, enable set again
    bound(4'h4);
    load_after(RET_CYC, 12'h123);
    rd_chk("gie_ret", OFF_STATUS, 32'h80);
    rd_chk("sp_ret", OFF_SP, 32'h100);
    $display("test return done");
    // relocated vectors, wake from sleep adds four cycles
    bus(1'b1, OFF_IRQCTL, 32'h2);
    pc_in <= 12'h345;
    bound(4'h8);
    check("ack5", src_ack, 8'h20);
    load_after(ENTRY_CYC + WAKE_CYC, 12'hc06);
    $display("test relocate done");
    // app lock with relocated vectors blocks entry while pc sits in the app region
    pulse(8'h04);
    lk_app <= 1'b1;
    bus(1'b1, OFF_STATUS, 32'h80);
    bound(4'h0);
    no_take("lock_app");
    @(posedge hclk);
    lk_app <= 1'b0;
    bound(4'h0);
    check("ack_unlock", src_ack, 8'h04);
    load_after(ENTRY_CYC, 12'hc03);
    $display("test lock done");
    // write one clears a flag, zero leaves it
    pulse(8'h01);
    bus(1'b1, OFF_FLAG, 32'h0);
    rd_chk("flag_w0", OFF_FLAG, 32'h01);
    bus(1'b1, OFF_FLAG, 32'h1);
    rd_chk("flag_w1", OFF_FLAG, 32'h0);
    // level source shows only while present
    src_level <= 8'h80;
    rd_chk("level_on", OFF_FLAG, 32'h80);
    src_level <= 8'h00;
    rd_chk("level_off", OFF_FLAG, 32'h0);
    // a level request gone before enabling never enters; a present one does
    bus(1'b1, OFF_EN, 32'h80);
    bus(1'b1, OFF_STATUS, 32'h80);
    bound(4'h0);
    no_take("level_gone");
    @(posedge hclk);
    src_level <= 8'h80;
    bound(4'h0);
    check("ack_level", src_ack, 8'h80);
    load_after(ENTRY_CYC, 12'hc08);
    @(posedge hclk);
    src_level <= 8'h00;
    fuse <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
    check("boot_reset_vec", rvec, 12'hc00);
    $display("test flags done");
    close_out();
  end
endmodule // icx_irq_ctrl_tb_top
`default_nettype wire
